// ### logic/eewc_count_clock.sv
/*
 * Count clock source: divides the system clock by 32, 64 or 128, or follows the
 * internal timer output, and gives one enable pulse per count clock period.
 * Assumes the timer output is a level synchronous to the system clock.
 */
`timescale 1ns/1ps
module eewc_count_clock
    import eewc_pkg::*;
(
    // Clock and reset.
    input wire logic clk,
    input wire logic rstn,
    // Selection and sources.
    input wire logic [2:0] clock_select,
    input wire logic timer_out,
    input wire logic osc_stopped,
    // Count clock enable.
    output logic tick
);
    logic [PRESCALE_W-1:0] pre_reg, pre_next;
    logic timer_q_reg, timer_q_next;
    logic tick_reg, tick_next;

    always_comb begin
        pre_next = osc_stopped ? pre_reg : pre_reg + 7'h01;
        timer_q_next = timer_out;
        tick_next = 1'b0;
        if (!osc_stopped) begin
            case (clock_select)
                SEL_DIV32: tick_next = (pre_reg & MASK_DIV32) == MASK_DIV32;
                SEL_DIV64: tick_next = (pre_reg & MASK_DIV64) == MASK_DIV64;
                SEL_DIV128: tick_next = (pre_reg & MASK_DIV128) == MASK_DIV128;
                // The timer output reaches this block even when its pin driver is off.
                SEL_TIMER: tick_next = timer_out && !timer_q_reg;
                default: tick_next = 1'b0;
            endcase
        end
    end

    always_ff @(posedge clk) begin
        if (!rstn) begin
            pre_reg <= 7'h00;
            timer_q_reg <= 1'b0;
            tick_reg <= 1'b0;
        end else begin
            pre_reg <= pre_next;
            timer_q_reg <= timer_q_next;
            tick_reg <= tick_next;
        end
    end

    assign tick = tick_reg;
endmodule

// ### logic/eewc_ctrl.sv
/*
 * Data EEPROM write control: control register on the special function register
 * port, the 32-byte data array, enable sequencing and the timed cell write.
 * Assumes the processor drives one register access and one array access per cycle,
 * and that the timer output and the stop indication are synchronous to REF_CLK.
 */
`timescale 1ns/1ps
module eewc_ctrl
    import eewc_pkg::*;
#(
    parameter int ARM_CYCLES = ARM_WAIT_CYCLES
)
(
    // Clock and reset.
    input wire logic REF_CLK,
    input wire logic RSTN,
    // Special function register port.
    input wire eewc_pkg::eewc_sfr_req_t SFR_REQ,
    output logic [7:0] SFR_RDATA,
    // Data array port.
    input wire eewc_pkg::eewc_array_req_t ARRAY_REQ,
    output logic [7:0] ARRAY_RDATA,
    output logic ARRAY_RVALID,
    // Count clock source and power mode.
    input wire logic TIMER_OUT,
    input wire logic STOP_MODE,
    // Status.
    output logic WRITE_IN_PROGRESS,
    output logic WRITE_CAPABLE,
    output logic LOW_POWER,
    output logic WRITE_DONE_INTERRUPT
);
    typedef enum logic [5:0] {
        ST_STANDBY = 6'b000001,
        ST_READ = 6'b000010,
        ST_ARM = 6'b000100,
        ST_READY = 6'b001000,
        ST_WRITE = 6'b010000,
        ST_LOCK = 6'b100000
    } eewc_state_t;

    logic [7:0] mem [ARRAY_DEPTH];

    eewc_state_t state_reg, state_next;
    logic array_read_enable_reg, array_read_enable_next;
    logic array_write_enable_reg, array_write_enable_next;
    logic [2:0] count_clock_select_reg, count_clock_select_next;
    logic [ARM_CNT_W-1:0] arm_cnt_reg, arm_cnt_next;
    logic tick_seen_reg, tick_seen_next;
    logic [7:0] period_cnt_reg, period_cnt_next;
    logic [ARRAY_AW-1:0] wr_addr_reg, wr_addr_next;
    logic [7:0] wr_data_reg, wr_data_next;
    logic [7:0] sfr_rdata_reg, sfr_rdata_next;
    logic [7:0] array_rdata_reg, array_rdata_next;
    logic array_rvalid_reg, array_rvalid_next;
    logic done_reg, done_next;
    logic low_power_reg, low_power_next;
    logic commit;
    logic tick;
    logic [7:0] ctrl_view;
    logic [7:0] ctrl_wr;
    logic sfr_hit;
    logic busy;
    logic write_ok;

    // Assembles the visible control byte with its fixed bits.
    function automatic logic [7:0] ctrl_byte(input logic [2:0] sel, input logic re, input logic st,
                                              input logic we);
        logic [7:0] v;
        v = 8'h00;
        v[BIT_FIXED_ONE] = 1'b1;
        v[BIT_FIXED_ZERO] = 1'b0;
        v[SEL_LSB +: 3] = sel;
        v[BIT_READ_ENABLE] = re;
        v[BIT_WRITE_STATUS] = st;
        v[BIT_WRITE_ENABLE] = we;
        return v;
    endfunction

    eewc_count_clock u_count_clock (
        .clk(REF_CLK),
        .rstn(RSTN),
        .clock_select(count_clock_select_reg),
        .timer_out(TIMER_OUT),
        .osc_stopped(STOP_MODE),
        .tick(tick)
    );

    assign busy = state_reg == ST_WRITE;
    assign ctrl_view = ctrl_byte(count_clock_select_reg, array_read_enable_reg, busy,
                                 array_write_enable_reg);

    // Register writes and the enable interlock.
    always_comb begin
        array_read_enable_next = array_read_enable_reg;
        array_write_enable_next = array_write_enable_reg;
        count_clock_select_next = count_clock_select_reg;
        sfr_rdata_next = sfr_rdata_reg;
        sfr_hit = SFR_REQ.addr == CTRL_ADDR;
        ctrl_wr = ctrl_view;
        if (sfr_hit && SFR_REQ.wr_byte) begin
            ctrl_wr = SFR_REQ.wdata;
        end else if (sfr_hit && SFR_REQ.wr_bit) begin
            ctrl_wr[SFR_REQ.bit_idx] = SFR_REQ.bit_val;
        end
        if (sfr_hit && (SFR_REQ.wr_byte || SFR_REQ.wr_bit)) begin
            // The status bit and the fixed bits are not stored from the write.
            count_clock_select_next = ctrl_wr[SEL_LSB +: 3];
            array_read_enable_next = ctrl_wr[BIT_READ_ENABLE];
            array_write_enable_next = ctrl_wr[BIT_WRITE_ENABLE] && ctrl_wr[BIT_READ_ENABLE];
        end
        if (sfr_hit && SFR_REQ.rd) begin
            sfr_rdata_next = ctrl_view;
        end
    end

    // Enable sequencing and the timed cell write.
    always_comb begin
        state_next = state_reg;
        arm_cnt_next = arm_cnt_reg;
        tick_seen_next = tick_seen_reg;
        period_cnt_next = period_cnt_reg;
        wr_addr_next = wr_addr_reg;
        wr_data_next = wr_data_reg;
        done_next = 1'b0;
        commit = 1'b0;
        write_ok = (state_reg == ST_READY) && !STOP_MODE;
        case (state_reg)
            ST_STANDBY: begin
                if (array_read_enable_reg && array_write_enable_reg) begin
                    state_next = ST_LOCK;
                end else if (array_read_enable_reg) begin
                    state_next = ST_READ;
                end
            end
            ST_READ: begin
                if (!array_read_enable_reg) begin
                    state_next = ST_STANDBY;
                end else if (array_write_enable_reg) begin
                    state_next = ST_ARM;
                    arm_cnt_next = '0;
                    tick_seen_next = 1'b0;
                end
            end
            ST_ARM: begin
                if (tick) begin
                    tick_seen_next = 1'b1;
                end
                if (!array_read_enable_reg) begin
                    state_next = ST_STANDBY;
                end else if (!array_write_enable_reg) begin
                    state_next = ST_READ;
                end else if (arm_cnt_reg == ARM_CNT_W'(ARM_CYCLES - 1)) begin
                    // A count clock that never ran while settling blocks writing until an enable is cleared.
                    state_next = (tick_seen_reg || tick) ? ST_READY : ST_LOCK;
                end else begin
                    arm_cnt_next = arm_cnt_reg + ARM_CNT_W'(1);
                end
            end
            ST_READY: begin
                if (!array_read_enable_reg) begin
                    state_next = ST_STANDBY;
                end else if (!array_write_enable_reg) begin
                    state_next = ST_READ;
                end else if (ARRAY_REQ.wr && write_ok) begin
                    state_next = ST_WRITE;
                    period_cnt_next = 8'h00;
                    wr_addr_next = ARRAY_REQ.addr;
                    wr_data_next = ARRAY_REQ.wdata;
                end
            end
            ST_WRITE: begin
                // New array writes are dropped here without touching the latched ones.
                if (tick && !STOP_MODE) begin
                    if (period_cnt_reg == WRITE_LAST) begin
                        commit = 1'b1;
                        done_next = 1'b1;
                        state_next = ST_READY;
                    end else begin
                        period_cnt_next = period_cnt_reg + 8'h01;
                    end
                end
            end
            ST_LOCK: begin
                if (!array_read_enable_reg) begin
                    state_next = ST_STANDBY;
                end else if (!array_write_enable_reg) begin
                    state_next = ST_READ;
                end
            end
            default: state_next = ST_STANDBY;
        endcase
    end

    // Array reads and the low-power indication.
    always_comb begin
        array_rdata_next = array_rdata_reg;
        array_rvalid_next = 1'b0;
        if (ARRAY_REQ.rd && array_read_enable_reg && !busy && !STOP_MODE) begin
            array_rdata_next = mem[ARRAY_REQ.addr];
            array_rvalid_next = 1'b1;
        end
        // Stop forces low power without touching the enables; halt has no say here.
        low_power_next = STOP_MODE || !array_read_enable_reg;
    end

    always_ff @(posedge REF_CLK) begin
        if (!RSTN) begin
            state_reg <= ST_STANDBY;
            array_read_enable_reg <= CTRL_RESET[BIT_READ_ENABLE];
            array_write_enable_reg <= CTRL_RESET[BIT_WRITE_ENABLE];
            count_clock_select_reg <= CTRL_RESET[SEL_LSB +: 3];
            arm_cnt_reg <= '0;
            tick_seen_reg <= 1'b0;
            period_cnt_reg <= 8'h00;
            wr_addr_reg <= '0;
            wr_data_reg <= 8'h00;
            sfr_rdata_reg <= 8'h00;
            array_rdata_reg <= 8'h00;
            array_rvalid_reg <= 1'b0;
            done_reg <= 1'b0;
            low_power_reg <= 1'b1;
        end else begin
            state_reg <= state_next;
            array_read_enable_reg <= array_read_enable_next;
            array_write_enable_reg <= array_write_enable_next;
            count_clock_select_reg <= count_clock_select_next;
            arm_cnt_reg <= arm_cnt_next;
            tick_seen_reg <= tick_seen_next;
            period_cnt_reg <= period_cnt_next;
            wr_addr_reg <= wr_addr_next;
            wr_data_reg <= wr_data_next;
            sfr_rdata_reg <= sfr_rdata_next;
            array_rdata_reg <= array_rdata_next;
            array_rvalid_reg <= array_rvalid_next;
            done_reg <= done_next;
            low_power_reg <= low_power_next;
        end
    end

    // The array cells keep their contents through reset.
    always_ff @(posedge REF_CLK) begin
        if (commit) begin
            mem[wr_addr_reg] <= wr_data_reg;
        end
    end

    assign SFR_RDATA = sfr_rdata_reg;
    assign ARRAY_RDATA = array_rdata_reg;
    assign ARRAY_RVALID = array_rvalid_reg;
    // The one-hot state bits drive the status pins straight from their flip-flops.
    assign WRITE_IN_PROGRESS = state_reg[4];
    assign WRITE_CAPABLE = state_reg[3];
    assign LOW_POWER = low_power_reg;
    assign WRITE_DONE_INTERRUPT = done_reg;
endmodule

// ### logic/eewc_pkg.sv
/*
 * Shared constants and carrier types for the data EEPROM write control block.
 * Assumes a single 200 MHz system clock and a synchronous, active-low reset.
 */
package eewc_pkg;

    // Control register location and layout.
    localparam logic [15:0] CTRL_ADDR = 16'hFFD8;
    localparam logic [7:0] CTRL_RESET = 8'h08;
    localparam int BIT_WRITE_ENABLE = 0;
    localparam int BIT_WRITE_STATUS = 1;
    localparam int BIT_READ_ENABLE = 2;
    localparam int BIT_FIXED_ONE = 3;
    localparam int SEL_LSB = 4;
    localparam int BIT_FIXED_ZERO = 7;

    // Count clock selection codes.
    localparam logic [2:0] SEL_DIV32 = 3'h2;
    localparam logic [2:0] SEL_DIV64 = 3'h3;
    localparam logic [2:0] SEL_DIV128 = 3'h4;
    localparam logic [2:0] SEL_TIMER = 3'h6;

    // Prescaler width and the mask of low bits that must all be one for each division.
    localparam int PRESCALE_W = 7;
    localparam logic [6:0] MASK_DIV32 = 7'h1F;
    localparam logic [6:0] MASK_DIV64 = 7'h3F;
    localparam logic [6:0] MASK_DIV128 = 7'h7F;

    // Cell write length in count clock periods.
    localparam int WRITE_PERIODS = 145;
    localparam logic [7:0] WRITE_LAST = 8'h90;

    // Array geometry.
    localparam int ARRAY_DEPTH = 32;
    localparam int ARRAY_AW = 5;

    // Settling time after the write enable is set, and its cycle count at 200 MHz.
    localparam int CLK_PERIOD_PS = 5000;
    localparam int ARM_WAIT_NS = 1000000;
    localparam int ARM_WAIT_CYCLES = (ARM_WAIT_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
    localparam int ARM_CNT_W = 18;

    typedef struct packed {
        logic [15:0] addr;
        logic wr_byte;
        logic wr_bit;
        logic [2:0] bit_idx;
        logic bit_val;
        logic [7:0] wdata;
        logic rd;
    } eewc_sfr_req_t;

    typedef struct packed {
        logic rd;
        logic wr;
        logic [ARRAY_AW-1:0] addr;
        logic [7:0] wdata;
    } eewc_array_req_t;

endpackage

// ### sim/eewc_cpu_model.sv
/* Processor model: issues one register or array access at a time.
   Drives requests at the falling edge of the clock it is given. */
`timescale 1ns/1ps
module eewc_cpu_model
    import eewc_pkg::*;
(
    // Clock.
    input wire logic clk,
    // Requests.
    output eewc_pkg::eewc_sfr_req_t sfr_req,
    output eewc_pkg::eewc_array_req_t array_req,
    // Answers.
    input wire logic [7:0] sfr_rdata,
    input wire logic [7:0] array_rdata,
    input wire logic array_rvalid
);
    initial begin
        sfr_req = '0;
        array_req = '0;
    end
    // Op bits: byte write, bit write, read; a bit write takes its index from d[6:4] and value from d[0].
    task automatic sfr(input logic [15:0] a, input logic [2:0] op, input logic [7:0] d, output logic [7:0] q);
        @(negedge clk);
        sfr_req <= '{addr: a, wr_byte: op[2], wr_bit: op[1], bit_idx: d[6:4], bit_val: d[0], wdata: d, rd: op[0]};
        @(negedge clk);
        q = sfr_rdata;
        sfr_req <= '{addr: 16'h0000, wdata: ~d, default: '0};
    endtask
    // Released lines carry inverted values so stale data never looks valid.
    task automatic arr(input logic [4:0] a, input logic w, input logic [7:0] d, output logic [7:0] q, output logic v);
        @(negedge clk);
        array_req <= '{rd: !w, wr: w, addr: a, wdata: d};
        @(negedge clk);
        q = array_rdata;
        v = array_rvalid;
        array_req <= '{rd: 1'b0, wr: 1'b0, addr: ~a, wdata: ~d};
    endtask
endmodule

// ### sim/eewc_ctrl_assertions.sv
/* Port checks for the write control block.
   Bound to every eewc_ctrl instance; sees its ports only. */
`timescale 1ns/1ps
module eewc_ctrl_assertions
    import eewc_pkg::*;
(
    // Clock and reset.
    input wire logic REF_CLK,
    input wire logic RSTN,
    // Inputs of the block.
    input wire eewc_pkg::eewc_sfr_req_t SFR_REQ,
    input wire eewc_pkg::eewc_array_req_t ARRAY_REQ,
    input wire logic TIMER_OUT,
    input wire logic STOP_MODE,
    // Outputs of the block.
    input wire logic [7:0] SFR_RDATA,
    input wire logic [7:0] ARRAY_RDATA,
    input wire logic ARRAY_RVALID,
    input wire logic WRITE_IN_PROGRESS,
    input wire logic WRITE_CAPABLE,
    input wire logic LOW_POWER,
    input wire logic WRITE_DONE_INTERRUPT
);
    default clocking @(posedge REF_CLK); endclocking
    default disable iff (!RSTN);
    logic ctrl_rd;
    assign ctrl_rd = SFR_REQ.rd && (SFR_REQ.addr == CTRL_ADDR);
    reset_state_a: assert property (disable iff (1'b0) !RSTN |=> !WRITE_IN_PROGRESS && !WRITE_CAPABLE && LOW_POWER)
        else $error("state after reset is wrong");
    fixed_bits_a: assert property (ctrl_rd |=> SFR_RDATA[BIT_FIXED_ONE] && !SFR_RDATA[BIT_FIXED_ZERO])
        else $error("fixed control bits read wrong");
    status_bit_a: assert property (ctrl_rd |=> SFR_RDATA[BIT_WRITE_STATUS] == $past(WRITE_IN_PROGRESS))
        else $error("status bit differs from write state");
    done_ends_write_a: assert property (WRITE_DONE_INTERRUPT |-> !WRITE_IN_PROGRESS && $past(WRITE_IN_PROGRESS))
        else $error("done pulse outside the end of a write");
    busy_fall_done_a: assert property ($fell(WRITE_IN_PROGRESS) |-> WRITE_DONE_INTERRUPT)
        else $error("write ended without done pulse");
    write_start_a: assert property (ARRAY_REQ.wr && WRITE_CAPABLE && !STOP_MODE
        |=> WRITE_IN_PROGRESS && !WRITE_CAPABLE)
        else $error("accepted write did not start");
    busy_refuse_a: assert property (ARRAY_REQ.rd && (WRITE_IN_PROGRESS || STOP_MODE) |=> !ARRAY_RVALID)
        else $error("read answered while busy or stopped");
    rvalid_cause_a: assert property (ARRAY_RVALID |-> $past(ARRAY_REQ.rd) && !$past(WRITE_IN_PROGRESS))
        else $error("read data without a legal read");
    stop_low_power_a: assert property (STOP_MODE |=> LOW_POWER)
        else $error("stop did not force low power");
    cover property (WRITE_DONE_INTERRUPT);
    cover property (ARRAY_RVALID);
    cover property ($rose(WRITE_CAPABLE));
endmodule
bind eewc_ctrl eewc_ctrl_assertions u_chk (.REF_CLK(REF_CLK), .RSTN(RSTN), .SFR_REQ(SFR_REQ),
    .ARRAY_REQ(ARRAY_REQ), .TIMER_OUT(TIMER_OUT), .STOP_MODE(STOP_MODE), .SFR_RDATA(SFR_RDATA),
    .ARRAY_RDATA(ARRAY_RDATA), .ARRAY_RVALID(ARRAY_RVALID), .WRITE_IN_PROGRESS(WRITE_IN_PROGRESS),
    .WRITE_CAPABLE(WRITE_CAPABLE), .LOW_POWER(LOW_POWER), .WRITE_DONE_INTERRUPT(WRITE_DONE_INTERRUPT));

// ### sim/tb_top.sv
/* Bench top: clock, reset, processor model, timer source and checks.
   Expects the design package compiled first; the checker binds itself. */
`timescale 1ns/1ps
module tb_top;
    import eewc_pkg::*;
    localparam int ARM = 200;
    typedef struct {logic [2:0] sel; int div;} eewc_row_t;
    // Each row is a division code and its divisor; runs are far shorter than in silicon.
    eewc_row_t rows [3] = '{'{SEL_DIV32, 32}, '{SEL_DIV64, 64}, '{SEL_DIV128, 128}};
    logic REF_CLK = 1'b0;
    logic RSTN = 1'b0;
    logic TIMER_OUT = 1'b0;
    logic STOP_MODE = 1'b0;
    eewc_sfr_req_t sfr_req;
    eewc_array_req_t array_req;
    logic [7:0] sfr_rdata, array_rdata, q;
    logic rvalid, wip, capable, low_power, done, v;
    int num_errors = 0;
    int total_checks = 0;
    int done_cnt = 0;
    int cycles = 0;
    int n;
    always #2.5 REF_CLK = ~REF_CLK;
    eewc_cpu_model cpu (.clk(REF_CLK), .sfr_req(sfr_req), .array_req(array_req), .sfr_rdata(sfr_rdata),
        .array_rdata(array_rdata), .array_rvalid(rvalid));
    eewc_ctrl #(.ARM_CYCLES(ARM)) DUT (.REF_CLK(REF_CLK), .RSTN(RSTN), .SFR_REQ(sfr_req), .SFR_RDATA(sfr_rdata),
        .ARRAY_REQ(array_req), .ARRAY_RDATA(array_rdata), .ARRAY_RVALID(rvalid), .TIMER_OUT(TIMER_OUT),
        .STOP_MODE(STOP_MODE), .WRITE_IN_PROGRESS(wip), .WRITE_CAPABLE(capable), .LOW_POWER(low_power),
        .WRITE_DONE_INTERRUPT(done));
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        total_checks++;
        if (got !== exp) begin
            num_errors++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic pulse(input int k);
        repeat (k) begin
            @(negedge REF_CLK);
            TIMER_OUT = 1'b1;
            repeat (4) @(negedge REF_CLK);
            TIMER_OUT = 1'b0;
            repeat (3) @(negedge REF_CLK);
        end
    endtask
    task automatic give_verdict;
        $display("errors=%0d checks=%0d", num_errors, total_checks);
        if (num_errors == 0 && total_checks > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask
    always @(posedge REF_CLK) begin
        cycles++;
        if (done === 1'b1) begin
            done_cnt++;
        end
        if (cycles == 60000) begin
            num_errors++;
            give_verdict();
        end
    end
    initial begin
        repeat (4) @(negedge REF_CLK);
        RSTN = 1'b1;
        cpu.sfr(CTRL_ADDR, 3'b001, 8'h00, q);
        chk(q, CTRL_RESET);
        chk({6'h0, low_power, wip}, 8'h02);
        cpu.sfr(CTRL_ADDR + 16'h0001, 3'b100, 8'h3C, q);
        cpu.sfr(CTRL_ADDR, 3'b100, 8'h01, q);
        cpu.sfr(CTRL_ADDR, 3'b001, 8'h00, q);
        chk(q, 8'h08);
        cpu.sfr(CTRL_ADDR, 3'b100, 8'h86, q);
        cpu.sfr(CTRL_ADDR, 3'b001, 8'h00, q);
        chk(q, 8'h0C);
        chk({7'h0, low_power}, 8'h00);
        // Write enable is clear before the oscillator stops.
        STOP_MODE = 1'b1;
        repeat (2) @(negedge REF_CLK);
        chk({7'h0, low_power}, 8'h01);
        cpu.arr(5'h00, 1'b0, 8'h00, q, v);
        chk({7'h0, v}, 8'h00);
        cpu.sfr(CTRL_ADDR, 3'b001, 8'h00, q);
        chk(q, 8'h0C);
        STOP_MODE = 1'b0;
        repeat (2) @(negedge REF_CLK);
        chk({7'h0, low_power}, 8'h00);
        foreach (rows[i]) begin
            cpu.sfr(CTRL_ADDR, 3'b100, {1'b0, rows[i].sel, 4'hC}, q);
            cpu.sfr(CTRL_ADDR, 3'b010, 8'h01, q);
            n = 0;
            while (capable !== 1'b1 && n < 2 * ARM) begin
                @(negedge REF_CLK);
                n++;
            end
            chk({6'h0, capable, n >= ARM - 4}, 8'h03);
            cpu.arr(5'(i), 1'b1, 8'hA5 ^ 8'(i), q, v);
            cpu.arr(5'(i), 1'b1, 8'h00, q, v);
            cpu.arr(5'(i), 1'b0, 8'h00, q, v);
            chk({7'h0, v}, 8'h00);
            cpu.sfr(CTRL_ADDR, 3'b001, 8'h00, q);
            chk(q, {1'b0, rows[i].sel, 4'hF});
            n = 0;
            while (done !== 1'b1 && n < 150 * rows[i].div) begin
                @(negedge REF_CLK);
                n++;
            end
            chk({7'h0, n > 144 * rows[i].div - 16 && n < 146 * rows[i].div}, 8'h01);
            cpu.arr(5'(i), 1'b0, 8'h00, q, v);
            chk(q, 8'hA5 ^ 8'(i));
            cpu.sfr(CTRL_ADDR, 3'b010, 8'h20, q);
            cpu.sfr(CTRL_ADDR, 3'b001, 8'h00, q);
            chk(q, {1'b0, rows[i].sel, 4'h8});
        end
        cpu.sfr(CTRL_ADDR, 3'b100, {1'b0, SEL_TIMER, 4'hC}, q);
        cpu.sfr(CTRL_ADDR, 3'b010, 8'h01, q);
        repeat (ARM + 50) @(negedge REF_CLK);
        pulse(3);
        chk({7'h0, capable}, 8'h00);
        cpu.sfr(CTRL_ADDR, 3'b010, 8'h00, q);
        cpu.sfr(CTRL_ADDR, 3'b010, 8'h01, q);
        pulse(30);
        chk({7'h0, capable}, 8'h01);
        n = done_cnt;
        cpu.arr(5'h1F, 1'b1, 8'h3C, q, v);
        pulse(144);
        repeat (8) @(negedge REF_CLK);
        chk({7'h0, wip}, 8'h01);
        pulse(1);
        chk({6'h0, wip, done_cnt == n + 1}, 8'h01);
        cpu.arr(5'h1F, 1'b0, 8'h00, q, v);
        chk(q, 8'h3C);
        RSTN = 1'b0;
        repeat (4) @(negedge REF_CLK);
        RSTN = 1'b1;
        cpu.sfr(CTRL_ADDR, 3'b001, 8'h00, q);
        chk(q, CTRL_RESET);
        // Both enables set in one write from standby must lock out writing, even with a running clock.
        cpu.sfr(CTRL_ADDR, 3'b100, {1'b0, SEL_DIV32, 4'hD}, q);
        repeat (ARM + 50) @(negedge REF_CLK);
        chk({7'h0, capable}, 8'h00);
        cpu.sfr(CTRL_ADDR, 3'b001, 8'h00, q);
        chk(q, {1'b0, SEL_DIV32, 4'hD});
        give_verdict();
    end
endmodule
